// file: sce_event_status.sv
// Purpose: per-channel event flags, mask and vector logic of a serial channel
// Assumes: datapath strobes are on i_ref_clk; cts and rxd are pins
// Notes: AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/10ps
`default_nettype none
module sce_event_status #(
  parameter int TMR_W = 24
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [11:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_cts_n,
  input wire logic i_rxd,
  input wire logic i_rx_bit_tick,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tx_end_marker,
  input wire logic i_tx_clock_ok,
  input wire logic i_tx_frame_start,
  input wire logic i_tx_byte_done,
  input wire logic i_collision,
  input wire logic i_nack_iframe,
  input wire logic i_rx_char_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic i_rx_parity_bad,
  input wire logic i_rx_byte,
  input wire logic i_rx_fifo_full,
  input wire logic i_rx_frame_end,
  input wire logic i_rx_addr_match,
  input wire logic i_rx_start_flag,
  input wire logic i_sframe_valid,
  input wire logic i_sframe_rnr,
  input wire logic i_bad_nr,
  input wire logic i_sframe_icontrol,
  input wire logic i_vector_ack,
  output logic o_vector_valid,
  output logic [4:0] o_vector_index,
  output logic o_event_int,
  output logic o_tx_halted,
  output logic o_tx_flow_stopped,
  output logic o_tx_abort,
  output logic o_tx_idle_seq,
  output logic o_rx_end_marker,
  output logic o_rx_discard,
  output logic o_rx_frame_overflow,
  output logic o_rx_stat_parity
);
  generate
    if (TMR_W < 1 || TMR_W > 24) begin : g_chk
      $error("TMR_W must be 1 to 24");
    end
  endgenerate

  function automatic logic [4:0] lowest_set(input logic [31:0] v);
    lowest_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = i[4:0];
      end
    end
  endfunction

  // registers
  logic [31:0] cfg0_reg, cfg1_reg, cfg2_reg, flow_reg, timer_reg, mask_reg, raw_reg;
  logic [31:0] raw_next, ev, clr, shown, pending, rdata_next;
  // bus state
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic addr_ok, rd_event;
  // pins
  logic [1:0] pin_q;
  logic cts_n_q, rxd_q, cts_prev_reg, rxd_prev_reg;
  // tx and rx state
  logic tx_run_reg, tx_reset_cmd_pend_reg, flow_stop_reg, brk_reg, to_armed_reg, rrdy_reg;
  logic [2:0] byte_cnt_reg;
  logic [3:0] low_cnt_reg, char_bits;
  logic [15:0] to_cnt_reg;
  logic [TMR_W-1:0] tmr_cnt_reg;
  logic [1:0] settle_reg;
  logic settled;
  sce_pkg::sce_mode_e mode;
  logic is_hdlc, is_async, is_bisync, auto_m;
  logic underrun, cts_fall, cts_rise, enough, stop_hit, resume_hit, term_hit, tmr_fire;
  logic brk_hit, brk_end, to_hit, rsc_hit, xpr_hit, cmd_tx_reset_cmd;

  assign mode = sce_pkg::sce_mode_e'(cfg0_reg[sce_pkg::CFG0_MODE_LSB +: 2]);
  assign is_hdlc = (mode == sce_pkg::MODE_HDLC);
  assign is_async = (mode == sce_pkg::MODE_ASYNC);
  assign is_bisync = (mode == sce_pkg::MODE_BISYNC);
  assign auto_m = is_hdlc & cfg0_reg[sce_pkg::CFG0_AUTO];

  sce_sync #(.W(2)) u_sync (
    .i_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_d({i_cts_n, i_rxd}),
    .i_rst_val(2'b11),
    .o_q(pin_q)
  );
  assign cts_n_q = pin_q[1];
  assign rxd_q = pin_q[0];

  // ---- bus slave
  assign addr_ok = i_hsel & i_htrans[1] & i_hready;
  assign rd_event = addr_ok & ~i_hwrite & (i_haddr == sce_pkg::OFS_EVENT);
  assign cmd_tx_reset_cmd = wr_pend_reg & (wr_addr_reg == sce_pkg::OFS_CMD)
                    & i_hwdata[sce_pkg::CMD_TX_RESET];
  assign shown = raw_reg & (~mask_reg | {32{cfg0_reg[sce_pkg::CFG0_VIS]}});

  always_comb begin
    rdata_next = 32'h00000000;
    if (i_haddr == sce_pkg::OFS_CFG0) begin
      rdata_next = cfg0_reg;
    end else if (i_haddr == sce_pkg::OFS_CFG1) begin
      rdata_next = cfg1_reg;
    end else if (i_haddr == sce_pkg::OFS_CFG2) begin
      rdata_next = cfg2_reg;
    end else if (i_haddr == sce_pkg::OFS_FLOW) begin
      rdata_next = flow_reg;
    end else if (i_haddr == sce_pkg::OFS_TIMER) begin
      rdata_next = timer_reg;
    end else if (i_haddr == sce_pkg::OFS_STAT) begin
      rdata_next = {28'h0000000, flow_stop_reg, tx_run_reg, rrdy_reg, ~cts_n_q};
    end else if (i_haddr == sce_pkg::OFS_MASK) begin
      rdata_next = mask_reg;
    end else if (i_haddr == sce_pkg::OFS_EVENT) begin
      rdata_next = shown;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      wr_pend_reg <= addr_ok & i_hwrite;
      wr_addr_reg <= i_haddr;
      if (addr_ok & ~i_hwrite) begin
        o_hrdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg0_reg <= sce_pkg::ZERO_RST;
      cfg1_reg <= sce_pkg::ZERO_RST;
      cfg2_reg <= sce_pkg::ZERO_RST;
      flow_reg <= sce_pkg::ZERO_RST;
      timer_reg <= sce_pkg::ZERO_RST;
      mask_reg <= sce_pkg::MASK_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == sce_pkg::OFS_CFG0) begin
        cfg0_reg <= i_hwdata;
      end else if (wr_addr_reg == sce_pkg::OFS_CFG1) begin
        cfg1_reg <= i_hwdata;
      end else if (wr_addr_reg == sce_pkg::OFS_CFG2) begin
        cfg2_reg <= i_hwdata;
      end else if (wr_addr_reg == sce_pkg::OFS_FLOW) begin
        flow_reg <= i_hwdata;
      end else if (wr_addr_reg == sce_pkg::OFS_TIMER) begin
        timer_reg <= i_hwdata;
      end else if (wr_addr_reg == sce_pkg::OFS_MASK) begin
        mask_reg <= i_hwdata;
      end
    end
  end

  // ---- transmitter control
  assign underrun = tx_run_reg & i_tx_fifo_empty & ~i_tx_end_marker
                    & (is_hdlc | is_bisync);
  assign xpr_hit = tx_reset_cmd_pend_reg & i_tx_clock_ok;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_run_reg <= 1'b0;
      tx_reset_cmd_pend_reg <= 1'b0;
      o_tx_abort <= 1'b0;
      o_tx_idle_seq <= 1'b0;
    end else begin
      o_tx_abort <= underrun & is_hdlc;
      o_tx_idle_seq <= underrun & is_bisync;
      if (cmd_tx_reset_cmd) begin
        tx_reset_cmd_pend_reg <= 1'b1;
        tx_run_reg <= 1'b0;
      end else if (xpr_hit) begin
        tx_reset_cmd_pend_reg <= 1'b0;
        tx_run_reg <= 1'b1;
      end else if (underrun) begin
        tx_run_reg <= 1'b0;
      end
    end
  end

  // ---- flow control characters
  assign stop_hit = is_async & i_rx_char_valid & (i_rx_char == flow_reg[7:0]);
  assign resume_hit = is_async & i_rx_char_valid & (i_rx_char == flow_reg[15:8]);
  assign term_hit = (is_async | is_bisync) & i_rx_char_valid & (i_rx_char == flow_reg[23:16]);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flow_stop_reg <= 1'b0;
    end else if (cfg2_reg[sce_pkg::CFG2_FLOW_EN]) begin
      if (stop_hit) begin
        flow_stop_reg <= 1'b1;
      end else if (resume_hit) begin
        flow_stop_reg <= 1'b0;
      end
    end
  end

  // ---- channel timer
  assign tmr_fire = timer_reg[sce_pkg::TMR_EN] & (tmr_cnt_reg == TMR_W'(1));

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tmr_cnt_reg <= '0;
    end else if (~timer_reg[sce_pkg::TMR_EN] | tmr_fire | (tmr_cnt_reg == '0)) begin
      tmr_cnt_reg <= timer_reg[TMR_W-1:0];
    end else begin
      tmr_cnt_reg <= tmr_cnt_reg - 1'b1;
    end
  end

  // ---- cts, bytes sent, repeat request
  // ignore cts edges while the synchroniser flushes after reset
  assign settled = (settle_reg == 2'h3);
  assign cts_fall = settled & cts_prev_reg & ~cts_n_q;
  assign cts_rise = settled & ~cts_prev_reg & cts_n_q;
  assign enough = (byte_cnt_reg == sce_pkg::XMR_MIN_BYTES);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cts_prev_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
      byte_cnt_reg <= 3'h0;
      settle_reg <= 2'h0;
    end else begin
      if (~settled) begin
        settle_reg <= settle_reg + 2'h1;
      end
      cts_prev_reg <= cts_n_q;
      rxd_prev_reg <= rxd_q;
      if (i_tx_frame_start) begin
        byte_cnt_reg <= 3'h0;
      end else if (i_tx_byte_done & ~enough) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  // ---- break and receive timeout
  assign char_bits = 4'(cfg2_reg[sce_pkg::CFG2_DBITS_LSB +: 2]) + 4'h5
                     + {3'h0, cfg2_reg[sce_pkg::CFG2_PAR_EN]}
                     + {3'h0, cfg2_reg[sce_pkg::CFG2_STOP2]} + 4'h1;
  assign brk_hit = is_async & ~brk_reg & ~rxd_q & i_rx_bit_tick
                   & (low_cnt_reg + 4'h1 == char_bits);
  assign brk_end = is_async & brk_reg & rxd_q & ~rxd_prev_reg;
  assign to_hit = is_async & cfg1_reg[sce_pkg::CFG1_TOE] & to_armed_reg & i_rx_bit_tick
                  & (to_cnt_reg + 16'h0001 == cfg1_reg[sce_pkg::CFG1_TIMEOUT_LENGTH_LSB +: 16]);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      low_cnt_reg <= 4'h0;
      brk_reg <= 1'b0;
    end else begin
      if (rxd_q) begin
        low_cnt_reg <= 4'h0;
      end else if (i_rx_bit_tick & (low_cnt_reg != 4'hf)) begin
        low_cnt_reg <= low_cnt_reg + 4'h1;
      end
      if (brk_hit) begin
        brk_reg <= 1'b1;
      end else if (brk_end | ~is_async) begin
        brk_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      to_cnt_reg <= 16'h0000;
      to_armed_reg <= 1'b0;
    end else if (i_rx_char_valid) begin
      to_cnt_reg <= 16'h0000;
      to_armed_reg <= 1'b1;
    end else if (to_hit) begin
      to_armed_reg <= 1'b0;
    end else if (i_rx_bit_tick & to_armed_reg) begin
      to_cnt_reg <= to_cnt_reg + 16'h0001;
    end
  end

  // ---- receive side strobes
  assign rsc_hit = auto_m & i_sframe_valid & (i_sframe_rnr == rrdy_reg);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rrdy_reg <= 1'b1;
      o_rx_discard <= 1'b0;
      o_rx_frame_overflow <= 1'b0;
      o_rx_end_marker <= 1'b0;
      o_rx_stat_parity <= 1'b0;
    end else begin
      if (rsc_hit) begin
        rrdy_reg <= ~i_sframe_rnr;
      end
      if (is_hdlc & i_rx_byte & i_rx_fifo_full) begin
        o_rx_discard <= 1'b1;
        o_rx_frame_overflow <= 1'b1;
      end else begin
        if (~i_rx_fifo_full) begin
          o_rx_discard <= 1'b0;
        end
        if (i_rx_frame_end) begin
          o_rx_frame_overflow <= 1'b0;
        end
      end
      o_rx_end_marker <= term_hit;
      o_rx_stat_parity <= i_rx_char_valid & i_rx_parity_bad & cfg2_reg[sce_pkg::CFG2_PAR_EN]
                          & cfg2_reg[sce_pkg::CFG2_APPEND];
    end
  end

  // ---- event assembly per mode
  always_comb begin
    ev = 32'h00000000;
    ev[sce_pkg::EV_TIMER] = tmr_fire;
    ev[sce_pkg::EV_CTS] = cts_fall | cts_rise;
    ev[sce_pkg::EV_XPR] = xpr_hit;
    if (is_hdlc) begin
      ev[sce_pkg::EV_UNDERRUN] = underrun;
      ev[sce_pkg::EV_XMR] = (auto_m & i_nack_iframe)
                            | ((i_collision | cts_rise) & enough);
      ev[sce_pkg::EV_RDO] = i_rx_byte & i_rx_fifo_full;
      ev[sce_pkg::EV_RFS] = cfg0_reg[sce_pkg::CFG0_ADDR_RECOG] ? i_rx_addr_match
                            : i_rx_start_flag;
      ev[sce_pkg::EV_RSC] = rsc_hit;
      ev[sce_pkg::EV_PCE] = auto_m & (i_bad_nr | i_sframe_icontrol);
    end else if (is_async) begin
      ev[sce_pkg::EV_STOP] = stop_hit;
      ev[sce_pkg::EV_RESUME] = resume_hit;
      ev[sce_pkg::EV_BRK] = brk_hit;
      ev[sce_pkg::EV_BREAK_ENDED] = brk_end;
      ev[sce_pkg::EV_TCD] = term_hit;
      ev[sce_pkg::EV_TIME] = to_hit;
      ev[sce_pkg::EV_PARITY_ERROR] = i_rx_char_valid & i_rx_parity_bad
                             & cfg2_reg[sce_pkg::CFG2_PAR_EN];
    end else if (is_bisync) begin
      ev[sce_pkg::EV_UNDERRUN] = underrun;
      ev[sce_pkg::EV_XMR] = cts_rise & enough;
      ev[sce_pkg::EV_TCD] = term_hit;
      ev[sce_pkg::EV_PARITY_ERROR] = i_rx_char_valid & i_rx_parity_bad
                             & cfg2_reg[sce_pkg::CFG2_PAR_EN];
    end
  end

  // ---- sticky flags, clear by read or by vector
  assign pending = raw_reg & ~mask_reg;

  always_comb begin
    clr = 32'h00000000;
    if (rd_event) begin
      clr = shown;
      if (~is_async) begin
        clr[sce_pkg::EV_UNDERRUN] = 1'b0;
      end
    end
    if (o_vector_valid & i_vector_ack) begin
      clr[o_vector_index] = 1'b1;
    end
    raw_next = (raw_reg & ~clr) | ev;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      raw_reg <= sce_pkg::ZERO_RST;
      o_vector_valid <= 1'b0;
      o_vector_index <= 5'h00;
      o_event_int <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      o_event_int <= |(raw_next & ~mask_reg);
      if (o_vector_valid) begin
        if (i_vector_ack) begin
          o_vector_valid <= 1'b0;
        end
      end else if (|pending) begin
        o_vector_valid <= 1'b1;
        o_vector_index <= lowest_set(pending);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_tx_halted <= 1'b1;
      o_tx_flow_stopped <= 1'b0;
    end else begin
      o_tx_halted <= ~tx_run_reg;
      o_tx_flow_stopped <= flow_stop_reg;
    end
  end
endmodule
`default_nettype wire

// file: sce_event_status_props.sv
// Purpose: port-level checks for the serial channel event status block
// Assumes: single clock domain, synchronous active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
module sce_event_status_props (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tx_end_marker,
  input wire logic i_rx_char_valid,
  input wire logic i_rx_parity_bad,
  input wire logic i_vector_ack,
  input wire logic o_vector_valid,
  input wire logic o_event_int,
  input wire logic o_tx_halted,
  input wire logic o_tx_abort,
  input wire logic o_tx_idle_seq,
  input wire logic o_rx_end_marker,
  input wire logic o_rx_stat_parity
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  chk_abort_cause: assert property (
    o_tx_abort |-> $past(i_tx_fifo_empty && !i_tx_end_marker) && !o_tx_halted ##1 !o_tx_abort)
    else $error("abort pulse without underrun");
  chk_idle_cause: assert property (
    o_tx_idle_seq |-> $past(i_tx_fifo_empty) && !o_tx_halted ##1 !o_tx_idle_seq)
    else $error("idle sequence without underrun");
  chk_underrun_halts: assert property (
    (o_tx_abort || o_tx_idle_seq) |=> o_tx_halted)
    else $error("transmitter not halted on underrun");
  chk_reset_state: assert property (
    disable iff (1'b0) i_rst |=> !o_event_int && !o_vector_valid && o_tx_halted)
    else $error("events not masked after reset");
  chk_marker_cause: assert property (
    o_rx_end_marker |-> $past(i_rx_char_valid) ##1 !o_rx_end_marker)
    else $error("end marker without character");
  chk_parity_cause: assert property (
    o_rx_stat_parity |-> $past(i_rx_char_valid && i_rx_parity_bad))
    else $error("parity status without bad character");
  chk_vector_cause: assert property (
    $rose(o_vector_valid) |-> $past(o_event_int))
    else $error("vector without unmasked event");
  chk_ack_drop: assert property (
    o_vector_valid && i_vector_ack |=> !o_vector_valid)
    else $error("vector still valid after ack");
  cover property (o_tx_abort);
  cover property (o_tx_idle_seq);
  cover property (o_vector_valid && i_vector_ack);
endmodule
bind sce_event_status sce_event_status_props chk_u (.i_ref_clk, .i_rst, .i_tx_fifo_empty,
  .i_tx_end_marker, .i_rx_char_valid, .i_rx_parity_bad, .i_vector_ack, .o_vector_valid,
  .o_event_int, .o_tx_halted, .o_tx_abort, .o_tx_idle_seq, .o_rx_end_marker, .o_rx_stat_parity);
`default_nettype wire

// file: sce_pkg.sv
// Purpose: constants for the serial channel event status block
// Assumes: one channel, registers on a 32-bit AHB-Lite bus
// Notes: event bit positions follow the per-mode status layout
package sce_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CFG0 = 12'h100;
  localparam logic [11:0] OFS_CFG1 = 12'h104;
  localparam logic [11:0] OFS_CFG2 = 12'h108;
  localparam logic [11:0] OFS_CMD = 12'h10c;
  localparam logic [11:0] OFS_FLOW = 12'h110;
  localparam logic [11:0] OFS_TIMER = 12'h114;
  localparam logic [11:0] OFS_STAT = 12'h118;
  localparam logic [11:0] OFS_MASK = 12'h154;
  localparam logic [11:0] OFS_EVENT = 12'h158;
  // reset values
  localparam logic [31:0] MASK_RST = 32'hffffffff;
  localparam logic [31:0] ZERO_RST = 32'h00000000;
  // channel_config_zero fields
  localparam int CFG0_MODE_LSB = 0;
  localparam int CFG0_AUTO = 2;
  localparam int CFG0_ADDR_RECOG = 3;
  localparam int CFG0_VIS = 4;
  // channel_config_one fields
  localparam int CFG1_TIMEOUT_LENGTH_LSB = 0;
  localparam int CFG1_TOE = 16;
  // channel_config_two fields
  localparam int CFG2_FLOW_EN = 0;
  localparam int CFG2_PAR_EN = 1;
  localparam int CFG2_APPEND = 2;
  localparam int CFG2_DBITS_LSB = 3;
  localparam int CFG2_STOP2 = 5;
  // command, timer and status fields
  localparam int CMD_TX_RESET = 0;
  localparam int TMR_EN = 24;
  localparam int STAT_CTS = 0;
  localparam int STAT_RRDY = 1;
  localparam int STAT_TX_RUN = 2;
  localparam int STAT_FLOW_STOP = 3;
  // event bit positions
  localparam int EV_TIMER = 15;
  localparam int EV_CTS = 14;
  localparam int EV_XMR = 13;
  localparam int EV_RESUME = 13;
  localparam int EV_XPR = 12;
  localparam int EV_BRK = 9;
  localparam int EV_BREAK_ENDED = 8;
  localparam int EV_RDO = 7;
  localparam int EV_TCD = 7;
  localparam int EV_RFS = 6;
  localparam int EV_TIME = 6;
  localparam int EV_RSC = 5;
  localparam int EV_PARITY_ERROR = 5;
  localparam int EV_PCE = 4;
  localparam int EV_UNDERRUN = 16;
  localparam int EV_STOP = 16;
  // repeat request on collision or cts rise needs this many bytes sent; the HDLC auto-mode NACK path does not
  localparam logic [2:0] XMR_MIN_BYTES = 3'h4;
  typedef enum logic [1:0] {
    MODE_HDLC = 2'b00,
    MODE_ASYNC = 2'b01,
    MODE_BISYNC = 2'b10
  } sce_mode_e;
endpackage

// file: sce_remote_station.sv
// Purpose: remote station model driving the receive line and clear-to-send
// Assumes: one receive bit time every four clocks
// Notes: idle line is mark, break holds space
`timescale 1ns/10ps
`default_nettype none
module sce_remote_station (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_break_req,
  input wire logic i_cts_drop,
  output logic o_rxd,
  output logic o_cts_n,
  output logic o_bit_tick
);
  logic [1:0] div_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign o_bit_tick = (div_reg == 2'h3);
  assign o_rxd = ~i_break_req;
  assign o_cts_n = i_cts_drop;
endmodule
`default_nettype wire

// file: sce_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module sce_sync #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  input wire logic [W-1:0] i_rst_val,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  generate
    if (W < 1) begin : g_chk
      $error("sce_sync width must be at least one");
    end
  endgenerate
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= i_rst_val;
      q_reg <= i_rst_val;
    end else begin
      meta_reg <= i_d;
      q_reg <= meta_reg;
    end
  end
  assign o_q = q_reg;
endmodule
`default_nettype wire

// file: serial_channel_event_status_test.sv
// Purpose: self-checking bench for the serial channel event status block
// Assumes: zero-wait AHB-Lite slave, remote station model on the pins
// Notes: event status reads clear the flags they show, except underrun in HDLC and BISYNC modes
`timescale 1ns/10ps
`default_nettype none
module serial_channel_event_status_test;
  localparam logic [11:0] EV = sce_pkg::OFS_EVENT;
  localparam logic [11:0] CFG0 = sce_pkg::OFS_CFG0;
  localparam logic [12:0] HP [5] = '{13'h100, 13'h8, 13'h200, 13'h400, 13'h800};
  localparam logic [31:0] HE [5] = '{32'h40, 32'h2000, 32'h20, 32'h10, 32'h10};
  localparam logic [7:0] AC [3] = '{8'h13, 8'h11, 8'h0d};
  localparam logic [31:0] AE [3] = '{32'h10000, 32'h2000, 32'h80};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic i_hsel = 1'b0, i_hwrite = 1'b0, i_tx_fifo_empty = 1'b0, i_tx_clock_ok = 1'b0;
  logic i_sframe_rnr = 1'b0, i_rx_parity_bad = 1'b0, break_detected = 1'b0, cts_drop = 1'b0;
  logic [11:0] i_haddr = 12'h000;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [7:0] i_rx_char = 8'h00;
  logic [12:0] pls = 13'h0;
  logic [31:0] o_hrdata, r;
  logic o_hreadyout, i_rxd, i_cts_n, i_rx_bit_tick, o_vector_valid, o_event_int;
  logic o_tx_halted, o_tx_flow_stopped, o_hresp, o_rx_discard, o_rx_frame_overflow;
  logic full = 1'b0;
  logic [4:0] o_vector_index;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  initial forever #2.5 clk = ~clk;
  sce_remote_station peer_u (.i_ref_clk(clk), .i_rst(rst), .i_break_req(break_detected),
    .i_cts_drop(cts_drop), .o_rxd(i_rxd), .o_cts_n(i_cts_n), .o_bit_tick(i_rx_bit_tick));
  sce_event_status #(.TMR_W(24)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hready(o_hreadyout), .i_hwdata, .o_hrdata,
    .o_hreadyout, .o_hresp, .i_cts_n, .i_rxd, .i_rx_bit_tick, .i_tx_fifo_empty,
    .i_tx_end_marker(1'b0),
    .i_tx_clock_ok, .i_tx_frame_start(pls[0]), .i_tx_byte_done(pls[1]), .i_collision(pls[2]),
    .i_nack_iframe(pls[3]), .i_rx_char_valid(pls[4]), .i_rx_char, .i_rx_parity_bad,
    .i_rx_byte(pls[5]), .i_rx_fifo_full(full), .i_rx_frame_end(pls[6]),
    .i_rx_addr_match(pls[7]), .i_rx_start_flag(pls[8]), .i_sframe_valid(pls[9]),
    .i_sframe_rnr, .i_bad_nr(pls[10]), .i_sframe_icontrol(pls[11]), .i_vector_ack(pls[12]),
    .o_vector_valid, .o_vector_index, .o_event_int, .o_tx_halted, .o_tx_flow_stopped,
    .o_tx_abort(), .o_tx_idle_seq(), .o_rx_end_marker(), .o_rx_discard,
    .o_rx_frame_overflow, .o_rx_stat_parity());
  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= wr;
    do @(posedge clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    do @(posedge clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(r, exp);
    check(o_hresp, 1'b0);
  endtask
  task automatic pulse(input logic [12:0] p);
    @(posedge clk);
    pls <= p;
    @(posedge clk);
    pls <= 13'h0;
  endtask
  // acks pending vectors, one pulse per vector
  task automatic ack_all();
    repeat (12) begin
      @(posedge clk);
      pls[12] <= (o_vector_valid === 1'b1) && !pls[12];
    end
    @(posedge clk);
    pls[12] <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(sce_pkg::OFS_MASK, sce_pkg::MASK_RST);
    rd(EV, 32'h0);
    rd(12'h000, 32'h0);
    wr(sce_pkg::OFS_MASK, 32'h0);
    for (int m = 0; m < 2; m++) begin
      wr(CFG0, (m == 0) ? 32'h4 : 32'h2);
      wr(sce_pkg::OFS_CMD, 32'h1);
      repeat (4) @(posedge clk);
      check(o_tx_halted, 1'b1);
      rd(EV, 32'h0);
      i_tx_clock_ok <= 1'b1;
      repeat (4) @(posedge clk);
      check(o_tx_halted, 1'b0);
      rd(EV, 32'h1000);
      ack_all();
      i_tx_fifo_empty <= 1'b1;
      repeat (3) @(posedge clk);
      check(o_tx_halted, 1'b1);
      check({o_vector_valid, o_vector_index}, {1'b1, 5'h10});
      rd(EV, 32'h10000);
      rd(EV, 32'h10000);
      ack_all();
      rd(EV, 32'h0);
      i_tx_fifo_empty <= 1'b0;
      i_tx_clock_ok <= 1'b0;
    end
    wr(CFG0, 32'h4);
    i_sframe_rnr <= 1'b1;
    foreach (HP[i]) begin
      pulse(HP[i]);
      rd(EV, HE[i]);
    end
    for (int k = 3; k < 5; k++) begin
      pulse(13'h1);
      repeat (k) pulse(13'h2);
      pulse(13'h4);
      rd(EV, (k == 4) ? 32'h2000 : 32'h0);
    end
    wr(CFG0, 32'hc);
    pulse(13'h80);
    rd(EV, 32'h40);
    full <= 1'b1;
    pulse(13'h20);
    rd(EV, 32'h80);
    check({o_rx_discard, o_rx_frame_overflow}, 2'h3);
    full <= 1'b0;
    pulse(13'h40);
    @(posedge clk);
    check({o_rx_discard, o_rx_frame_overflow}, 2'h0);
    ack_all();
    wr(CFG0, 32'h1);
    wr(sce_pkg::OFS_CFG2, 32'h1);
    wr(sce_pkg::OFS_FLOW, 32'h000d1113);
    foreach (AC[i]) begin
      i_rx_char <= AC[i];
      pulse(13'h10);
      rd(EV, AE[i]);
      check(o_tx_flow_stopped, i == 0);
    end
    wr(sce_pkg::OFS_CFG2, 32'h6);
    i_rx_parity_bad <= 1'b1;
    i_rx_char <= 8'h41;
    pulse(13'h10);
    rd(EV, 32'h20);
    i_rx_parity_bad <= 1'b0;
    wr(sce_pkg::OFS_CFG1, 32'h10004);
    pulse(13'h10);
    repeat (30) @(posedge clk);
    wr(sce_pkg::OFS_CFG1, 32'h0);
    rd(EV, 32'h40);
    break_detected <= 1'b1;
    repeat (40) @(posedge clk);
    break_detected <= 1'b0;
    repeat (6) @(posedge clk);
    rd(EV, 32'h300);
    wr(sce_pkg::OFS_TIMER, 32'h01000008);
    repeat (12) @(posedge clk);
    wr(sce_pkg::OFS_TIMER, 32'h0);
    rd(EV, 32'h8000);
    ack_all();
    wr(sce_pkg::OFS_MASK, 32'hffffffff);
    cts_drop <= 1'b1;
    repeat (6) @(posedge clk);
    rd(EV, 32'h0);
    check(o_event_int, 1'b0);
    wr(CFG0, 32'h11);
    rd(EV, 32'h4000);
    xfer(1'b0, sce_pkg::OFS_STAT, 32'h0);
    check(r[0], 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
